// >>> verilog/ioa_pkg.sv
// Operation
// - Memory is a sequence of bytes, each reached by its own 16-bit address.
// - The address space covers 65,536 bytes of mixed read-only and read/write storage.
// - Bit 0 of a data byte is its least significant bit and bit 7 its most significant bit.
// - An instruction is one, two or three bytes long, held at consecutive addresses.
// - An instruction is known by the address of its first byte.
// - Multi-byte data lies at consecutive addresses, least significant byte lowest.
// - A direct data address takes byte two as its low half and byte three as its high half.
// - Register addressing takes the operand from the register or pair named in the opcode.
// - Register-indirect data addressing uses a pair, first register high and second low.
// - An immediate operand is one byte or two bytes, low byte first.
// - Without a branch or interrupt, instructions are fetched at increasing addresses.
// - A direct branch target takes byte two low and byte three high, except the vector call.
// - A register-indirect branch target comes from a pair, first register high.
// - The one-byte vector call jumps to eight times its three-bit field.
// - The register field codes A=111, B=000, C=001, D=010, E=011, H=100, L=101.
// - The pair field codes B-C=00, D-E=01, H-L=10, stack pointer=11.
package ioa_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] RESET_PC = 16'h0000;
   localparam logic [ADDR_W-1:0] RESET_SP = 16'h0000;
   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   // Register field codes.
   localparam logic [2:0] REG_A = 3'h7;
   localparam logic [2:0] REG_B = 3'h0;
   localparam logic [2:0] REG_C = 3'h1;
   localparam logic [2:0] REG_D = 3'h2;
   localparam logic [2:0] REG_E = 3'h3;
   localparam logic [2:0] REG_H = 3'h4;
   localparam logic [2:0] REG_L = 3'h5;
   localparam logic [2:0] REG_MEM = 3'h6;
   // Register pair field codes.
   localparam logic [1:0] PAIR_BC = 2'h0;
   localparam logic [1:0] PAIR_DE = 2'h1;
   localparam logic [1:0] PAIR_HL = 2'h2;
   localparam logic [1:0] PAIR_SP = 2'h3;
   // Field positions inside the first byte.
   localparam int DST_LSB = 3;
   localparam int PAIR_LSB = 4;
   localparam int VEC_SHIFT = 3;
   // Addressing modes reported for each instruction.
   typedef enum logic [2:0] {
      IOA_MODE_NONE = 3'b000,
      IOA_MODE_DIRECT = 3'b001,
      IOA_MODE_REG = 3'b010,
      IOA_MODE_INDIRECT = 3'b011,
      IOA_MODE_IMM = 3'b100
   } ioa_mode_e;
   // Branch target kinds.
   typedef enum logic [1:0] {
      IOA_BR_NONE = 2'b00,
      IOA_BR_DIRECT = 2'b01,
      IOA_BR_INDIRECT = 2'b10,
      IOA_BR_VECTOR = 2'b11
   } ioa_branch_e;
   typedef enum logic [2:0] {
      IOA_ST_FETCH = 3'b000,
      IOA_ST_WAIT1 = 3'b001,
      IOA_ST_BYTE2 = 3'b010,
      IOA_ST_BYTE3 = 3'b011,
      IOA_ST_EXEC = 3'b100
   } ioa_state_e;
endpackage

// >>> verilog/ioa_decode.sv
`timescale 1ns/1ns
// Pure decode of the first instruction byte into length, mode and branch kind.
module ioa_decode
   import ioa_pkg::*;
(
   // First byte.
   input wire logic [DATA_W-1:0] opcode,
   // Decode results.
   output logic [1:0] length,
   output ioa_mode_e mode,
   output ioa_branch_e branch,
   output logic pair_mem_op
);
   logic [2:0] dest_register_field;
   logic [2:0] source_register_field;
   logic [1:0] register_pair_field;

   always_comb begin
      dest_register_field = opcode[DST_LSB +: 3];
      source_register_field = opcode[2:0];
      register_pair_field = opcode[PAIR_LSB +: 2];
      length = LEN_ONE;
      mode = IOA_MODE_NONE;
      branch = IOA_BR_NONE;
      pair_mem_op = 1'b0;
      case (opcode[7:6])
         2'b01: begin
            // Moves between registers or through the H-L pair.
            if (dest_register_field == REG_MEM || source_register_field == REG_MEM) begin
               mode = IOA_MODE_INDIRECT;
            end else begin
               mode = IOA_MODE_REG;
            end
         end
         2'b10: begin
            mode = (source_register_field == REG_MEM) ? IOA_MODE_INDIRECT : IOA_MODE_REG;
         end
         2'b00: begin
            case (source_register_field)
               3'h6: begin
                  length = LEN_TWO;
                  mode = IOA_MODE_IMM;
               end
               3'h1: begin
                  if (!opcode[3]) begin
                     length = LEN_THREE;
                     mode = IOA_MODE_IMM;
                  end else begin
                     mode = IOA_MODE_REG;
                  end
               end
               3'h2: begin
                  if (opcode[5]) begin
                     length = LEN_THREE;
                     mode = IOA_MODE_DIRECT;
                  end else begin
                     mode = IOA_MODE_INDIRECT;
                     pair_mem_op = 1'b1;
                  end
               end
               default: begin
                  mode = IOA_MODE_REG;
               end
            endcase
         end
         default: begin
            case (source_register_field)
               3'h2, 3'h4: begin
                  length = LEN_THREE;
                  branch = IOA_BR_DIRECT;
                  mode = IOA_MODE_DIRECT;
               end
               3'h3: begin
                  if (dest_register_field == 3'h0) begin
                     length = LEN_THREE;
                     branch = IOA_BR_DIRECT;
                  end else if (dest_register_field[2:1] == 2'b01) begin
                     length = LEN_TWO;
                     mode = IOA_MODE_IMM;
                  end
               end
               3'h5: begin
                  if (!opcode[3]) begin
                     mode = IOA_MODE_REG;
                  end else begin
                     length = LEN_THREE;
                     branch = IOA_BR_DIRECT;
                  end
               end
               3'h6: begin
                  length = LEN_TWO;
                  mode = IOA_MODE_IMM;
               end
               3'h7: begin
                  branch = IOA_BR_VECTOR;
               end
               3'h1: begin
                  if (opcode[5:3] == 3'h5) begin
                     branch = IOA_BR_INDIRECT;
                     mode = IOA_MODE_INDIRECT;
                  end
               end
               default: begin
                  mode = IOA_MODE_NONE;
               end
            endcase
         end
      endcase
   end
endmodule

// >>> verilog/ioa_addressing.sv
`timescale 1ns/1ns
// Instruction fetch and operand address formation.
module ioa_addressing
   import ioa_pkg::*;
(
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Memory read port.
   output logic [ioa_pkg::ADDR_W-1:0] MEM_ADDR,
   output logic MEM_RD,
   input wire logic [ioa_pkg::DATA_W-1:0] MEM_RDATA,
   input wire logic MEM_VALID,
   // Register file view.
   input wire logic [ioa_pkg::DATA_W-1:0] REG_B_IN,
   input wire logic [ioa_pkg::DATA_W-1:0] REG_C_IN,
   input wire logic [ioa_pkg::DATA_W-1:0] REG_D_IN,
   input wire logic [ioa_pkg::DATA_W-1:0] REG_E_IN,
   input wire logic [ioa_pkg::DATA_W-1:0] REG_H_IN,
   input wire logic [ioa_pkg::DATA_W-1:0] REG_L_IN,
   input wire logic [ioa_pkg::DATA_W-1:0] REG_A_IN,
   input wire logic [ioa_pkg::ADDR_W-1:0] SP_IN,
   // Execution handshake.
   input wire logic EXEC_DONE,
   input wire logic BRANCH_TAKEN,
   // Decoded instruction.
   output logic INSTR_VALID,
   output logic [ioa_pkg::ADDR_W-1:0] INSTR_ADDR,
   output logic [ioa_pkg::DATA_W-1:0] INSTR_OPCODE,
   output logic [1:0] INSTR_LEN,
   output ioa_pkg::ioa_mode_e INSTR_MODE,
   output logic [ioa_pkg::ADDR_W-1:0] OPERAND_ADDR,
   output logic [ioa_pkg::ADDR_W-1:0] IMM_DATA,
   output logic [ioa_pkg::DATA_W-1:0] SRC_OPERAND,
   output logic [ioa_pkg::ADDR_W-1:0] PAIR_OPERAND,
   output ioa_pkg::ioa_branch_e BRANCH_KIND,
   output logic [ioa_pkg::ADDR_W-1:0] BRANCH_TARGET
);
   import ioa_pkg::*;

   ioa_state_e state_r, state_nxt;
   logic [ADDR_W-1:0] pc_r, pc_nxt;
   logic [ADDR_W-1:0] iaddr_r, iaddr_nxt;
   logic [DATA_W-1:0] op_r, op_nxt;
   logic [DATA_W-1:0] b2_r, b2_nxt;
   logic [DATA_W-1:0] b3_r, b3_nxt;
   logic [ADDR_W-1:0] maddr_r, maddr_nxt;
   logic mrd_r, mrd_nxt;
   logic valid_r, valid_nxt;
   logic [1:0] len_r, len_nxt;
   ioa_mode_e mode_r, mode_nxt;
   ioa_branch_e bk_r, bk_nxt;
   logic [ADDR_W-1:0] oaddr_r, oaddr_nxt;
   logic [ADDR_W-1:0] imm_r, imm_nxt;
   logic [DATA_W-1:0] src_r, src_nxt;
   logic [ADDR_W-1:0] pairv_r, pairv_nxt;
   logic [ADDR_W-1:0] btgt_r, btgt_nxt;
   logic [1:0] dec_len;
   ioa_mode_e dec_mode;
   ioa_branch_e dec_branch;
   logic dec_pair_mem;
   logic [DATA_W-1:0] cur_op;

   // Register field lookup, shared by source operand selection.
   function automatic logic [DATA_W-1:0] reg_sel(input logic [2:0] f);
      case (f)
         REG_B: reg_sel = REG_B_IN;
         REG_C: reg_sel = REG_C_IN;
         REG_D: reg_sel = REG_D_IN;
         REG_E: reg_sel = REG_E_IN;
         REG_H: reg_sel = REG_H_IN;
         REG_L: reg_sel = REG_L_IN;
         REG_A: reg_sel = REG_A_IN;
         default: reg_sel = RESET_BYTE;
      endcase
   endfunction

   // Pair lookup: first register is the high half, second the low half.
   function automatic logic [ADDR_W-1:0] pair_sel(input logic [1:0] f);
      case (f)
         PAIR_BC: pair_sel = {REG_B_IN, REG_C_IN};
         PAIR_DE: pair_sel = {REG_D_IN, REG_E_IN};
         PAIR_HL: pair_sel = {REG_H_IN, REG_L_IN};
         default: pair_sel = SP_IN;
      endcase
   endfunction

   // Inside a pending fetch the opcode is the byte arriving now.
   assign cur_op = (state_r == IOA_ST_WAIT1) ? MEM_RDATA : op_r;

   ioa_decode u_decode (
      .opcode(cur_op),
      .length(dec_len),
      .mode(dec_mode),
      .branch(dec_branch),
      .pair_mem_op(dec_pair_mem)
   );

   always_comb begin
      state_nxt = state_r;
      pc_nxt = pc_r;
      iaddr_nxt = iaddr_r;
      op_nxt = op_r;
      b2_nxt = b2_r;
      b3_nxt = b3_r;
      maddr_nxt = maddr_r;
      mrd_nxt = 1'b0;
      valid_nxt = valid_r;
      len_nxt = len_r;
      mode_nxt = mode_r;
      bk_nxt = bk_r;
      oaddr_nxt = oaddr_r;
      imm_nxt = imm_r;
      src_nxt = src_r;
      pairv_nxt = pairv_r;
      btgt_nxt = btgt_r;
      case (state_r)
         IOA_ST_FETCH: begin
            maddr_nxt = pc_r;
            iaddr_nxt = pc_r;
            mrd_nxt = 1'b1;
            pc_nxt = pc_r + 16'h0001;
            state_nxt = IOA_ST_WAIT1;
         end
         IOA_ST_WAIT1: begin
            if (MEM_VALID) begin
               op_nxt = MEM_RDATA;
               len_nxt = dec_len;
               mode_nxt = dec_mode;
               bk_nxt = dec_branch;
               if (dec_len == LEN_ONE) begin
                  state_nxt = IOA_ST_EXEC;
               end else begin
                  maddr_nxt = pc_r;
                  mrd_nxt = 1'b1;
                  pc_nxt = pc_r + 16'h0001;
                  state_nxt = IOA_ST_BYTE2;
               end
            end
         end
         IOA_ST_BYTE2: begin
            if (MEM_VALID) begin
               b2_nxt = MEM_RDATA;
               if (len_r == LEN_TWO) begin
                  state_nxt = IOA_ST_EXEC;
               end else begin
                  maddr_nxt = pc_r;
                  mrd_nxt = 1'b1;
                  pc_nxt = pc_r + 16'h0001;
                  state_nxt = IOA_ST_BYTE3;
               end
            end
         end
         IOA_ST_BYTE3: begin
            if (MEM_VALID) begin
               b3_nxt = MEM_RDATA;
               state_nxt = IOA_ST_EXEC;
            end
         end
         IOA_ST_EXEC: begin
            if (!valid_r) begin
               // All operand bytes are in; present the instruction.
               valid_nxt = 1'b1;
               src_nxt = reg_sel(op_r[2:0]);
               pairv_nxt = pair_sel(op_r[PAIR_LSB +: 2]);
               imm_nxt = (len_r == LEN_THREE) ? {b3_r, b2_r} : {8'h00, b2_r};
               oaddr_nxt = RESET_PC;
               btgt_nxt = RESET_PC;
               case (mode_r)
                  IOA_MODE_DIRECT: oaddr_nxt = {b3_r, b2_r};
                  IOA_MODE_INDIRECT: begin
                     oaddr_nxt = dec_pair_mem ? pair_sel(op_r[PAIR_LSB +: 2]) : pair_sel(PAIR_HL);
                  end
                  default: oaddr_nxt = RESET_PC;
               endcase
               case (bk_r)
                  IOA_BR_DIRECT: btgt_nxt = {b3_r, b2_r};
                  IOA_BR_INDIRECT: btgt_nxt = pair_sel(PAIR_HL);
                  IOA_BR_VECTOR: btgt_nxt = {10'h000, op_r[DST_LSB +: 3], 3'h0};
                  default: btgt_nxt = RESET_PC;
               endcase
            end else if (EXEC_DONE) begin
               valid_nxt = 1'b0;
               if (BRANCH_TAKEN && bk_r != IOA_BR_NONE) begin
                  pc_nxt = btgt_r;
               end
               state_nxt = IOA_ST_FETCH;
            end
         end
         default: begin
            state_nxt = IOA_ST_FETCH;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         state_r <= IOA_ST_FETCH;
         pc_r <= RESET_PC;
         iaddr_r <= RESET_PC;
         op_r <= RESET_BYTE;
         b2_r <= RESET_BYTE;
         b3_r <= RESET_BYTE;
         maddr_r <= RESET_PC;
         mrd_r <= 1'b0;
         valid_r <= 1'b0;
         len_r <= LEN_ONE;
         mode_r <= IOA_MODE_NONE;
         bk_r <= IOA_BR_NONE;
         oaddr_r <= RESET_PC;
         imm_r <= RESET_PC;
         src_r <= RESET_BYTE;
         pairv_r <= RESET_SP;
         btgt_r <= RESET_PC;
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         iaddr_r <= iaddr_nxt;
         op_r <= op_nxt;
         b2_r <= b2_nxt;
         b3_r <= b3_nxt;
         maddr_r <= maddr_nxt;
         mrd_r <= mrd_nxt;
         valid_r <= valid_nxt;
         len_r <= len_nxt;
         mode_r <= mode_nxt;
         bk_r <= bk_nxt;
         oaddr_r <= oaddr_nxt;
         imm_r <= imm_nxt;
         src_r <= src_nxt;
         pairv_r <= pairv_nxt;
         btgt_r <= btgt_nxt;
      end
   end

   assign MEM_ADDR = maddr_r;
   assign MEM_RD = mrd_r;
   assign INSTR_VALID = valid_r;
   assign INSTR_ADDR = iaddr_r;
   assign INSTR_OPCODE = op_r;
   assign INSTR_LEN = len_r;
   assign INSTR_MODE = mode_r;
   assign OPERAND_ADDR = oaddr_r;
   assign IMM_DATA = imm_r;
   assign SRC_OPERAND = src_r;
   assign PAIR_OPERAND = pairv_r;
   assign BRANCH_KIND = bk_r;
   assign BRANCH_TARGET = btgt_r;
endmodule

// >>> test/ioa_props.sv
`timescale 1ns/1ns
module ioa_props
   import ioa_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [15:0] MEM_ADDR,
   input wire logic MEM_RD,
   input wire logic [7:0] REG_H_IN,
   input wire logic [7:0] REG_L_IN,
   input wire logic EXEC_DONE,
   input wire logic BRANCH_TAKEN,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR_ADDR,
   input wire logic [7:0] INSTR_OPCODE,
   input wire logic [1:0] INSTR_LEN,
   input wire ioa_pkg::ioa_mode_e INSTR_MODE,
   input wire ioa_pkg::ioa_branch_e BRANCH_KIND,
   input wire logic [15:0] BRANCH_TARGET
);
   logic [15:0] last_rd_r;
   always_ff @(posedge CORE_CLK) begin
      if (MEM_RD) begin
         last_rd_r <= MEM_ADDR;
      end
   end
   default clocking dflt @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   sequence gap_then_fetch;
      !INSTR_VALID ##1 MEM_RD;
   endsequence
   sequence retire_seq;
      INSTR_VALID && EXEC_DONE;
   endsequence
   instr_hold_a: assert property (INSTR_VALID && !EXEC_DONE |=> INSTR_VALID && $stable(INSTR_ADDR))
      else $error("instruction dropped before done");
   retire_drop_a: assert property (retire_seq |=> !INSTR_VALID)
      else $error("instruction still valid after done");
   rd_pulse_a: assert property (MEM_RD |=> !MEM_RD)
      else $error("read request longer than one cycle");
   no_fetch_a: assert property (INSTR_VALID |-> !MEM_RD)
      else $error("fetch while instruction presented");
   last_byte_a: assert property ($rose(INSTR_VALID) |-> last_rd_r == INSTR_ADDR + INSTR_LEN - 16'h1)
      else $error("operand bytes not consecutive");
   direct_len_a: assert property (INSTR_VALID && INSTR_MODE == IOA_MODE_DIRECT |-> INSTR_LEN == LEN_THREE)
      else $error("direct operand without three bytes");
   seq_fetch_a: assert property (retire_seq ##0 !(BRANCH_TAKEN && BRANCH_KIND != IOA_BR_NONE)
      |=> gap_then_fetch ##0 MEM_ADDR == $past(INSTR_ADDR, 2) + $past(INSTR_LEN, 2))
      else $error("next fetch not at following address");
   branch_fetch_a: assert property (retire_seq ##0 (BRANCH_TAKEN && BRANCH_KIND != IOA_BR_NONE)
      |=> gap_then_fetch ##0 MEM_ADDR == $past(BRANCH_TARGET, 2))
      else $error("branch fetch not at target");
   vector_tgt_a: assert property (INSTR_VALID && BRANCH_KIND == IOA_BR_VECTOR
      |-> BRANCH_TARGET == {10'h000, INSTR_OPCODE[5:3], 3'h0})
      else $error("vector target wrong");
   pair_tgt_a: assert property (INSTR_VALID && BRANCH_KIND == IOA_BR_INDIRECT
      |-> BRANCH_TARGET == {REG_H_IN, REG_L_IN})
      else $error("indirect target wrong");
endmodule
bind ioa_addressing ioa_props chk (.CORE_CLK, .RESET_N, .MEM_ADDR, .MEM_RD, .REG_H_IN, .REG_L_IN, .EXEC_DONE,
   .BRANCH_TAKEN, .INSTR_VALID, .INSTR_ADDR, .INSTR_OPCODE, .INSTR_LEN, .INSTR_MODE, .BRANCH_KIND, .BRANCH_TARGET);

// >>> test/ioa_mem_model.sv
`timescale 1ns/1ns
module ioa_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic [15:0] addr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic valid
);
   logic [7:0] mem [0:65535];
   logic [15:0] addr_r;
   int wait_r = 0;
   initial begin
      rdata = 8'h5a;
      valid = 1'b0;
   end
   // The data lines toggle whenever no byte is being answered.
   always @(posedge clk) begin
      valid <= 1'b0;
      rdata <= ~rdata;
      if (!rst_n) begin
         wait_r <= 0;
      end else if (rd && !slow) begin
         valid <= 1'b1;
         rdata <= mem[addr];
      end else if (rd) begin
         addr_r <= addr;
         wait_r <= 3;
      end else if (wait_r > 1) begin
         wait_r <= wait_r - 1;
      end else if (wait_r == 1) begin
         valid <= 1'b1;
         rdata <= mem[addr_r];
         wait_r <= 0;
      end
   end
endmodule

// >>> test/instruction_operand_addressing_tb.sv
`timescale 1ns/1ns
module instruction_operand_addressing_tb;
   import ioa_pkg::*;
   typedef struct {
      logic [15:0] addr;
      logic [7:0] op;
      logic [1:0] len;
      logic [2:0] mode;
      logic [1:0] sel;
      logic [15:0] v0;
      logic [15:0] pv;
      logic [1:0] bk;
   } ioa_exp_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic done = 1'b0;
   logic take = 1'b0;
   logic slow = 1'b0;
   logic [15:0] sp = 16'h0000;
   logic [7:0] rg [8] = '{default: 8'h00};
   logic [15:0] mem_addr, ia, oaddr, imm, pairo, bt;
   logic [7:0] mem_rdata, iop, src;
   logic mem_rd, mem_valid, iv, ivp;
   logic [1:0] ilen;
   ioa_mode_e imode;
   ioa_branch_e bk;
   logic [31:0] seed = 32'h35e1;
   logic [15:0] pc = 16'h0000;
   ioa_exp_s q[$];
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   ioa_addressing uut (.CORE_CLK(clk), .RESET_N(rst_n), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
      .MEM_RDATA(mem_rdata), .MEM_VALID(mem_valid), .REG_B_IN(rg[0]), .REG_C_IN(rg[1]), .REG_D_IN(rg[2]),
      .REG_E_IN(rg[3]), .REG_H_IN(rg[4]), .REG_L_IN(rg[5]), .REG_A_IN(rg[7]), .SP_IN(sp), .EXEC_DONE(done),
      .BRANCH_TAKEN(take), .INSTR_VALID(iv), .INSTR_ADDR(ia), .INSTR_OPCODE(iop), .INSTR_LEN(ilen),
      .INSTR_MODE(imode), .OPERAND_ADDR(oaddr), .IMM_DATA(imm), .SRC_OPERAND(src), .PAIR_OPERAND(pairo),
      .BRANCH_KIND(bk), .BRANCH_TARGET(bt));
   ioa_mem_model mdl (.clk(clk), .rst_n(rst_n), .slow(slow), .addr(mem_addr), .rd(mem_rd),
      .rdata(mem_rdata), .valid(mem_valid));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] pair_of(input logic [1:0] p);
      return (p == 2'h3) ? sp : {rg[{p, 1'b0}], rg[{p, 1'b1}]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Loads one instruction at the current address, notes what must appear, then retires it.
   task automatic exec(input logic [7:0] op, input int k);
      ioa_exp_s e;
      logic [7:0] b2;
      logic [7:0] b3;
      int n;
      {b3, b2} = 16'(rnd());
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rg[i] <= 8'(rnd());
      end
      sp <= 16'(rnd());
      slow <= 1'(rnd());
      #1;
      mdl.mem[pc] = op;
      mdl.mem[16'(pc + 16'h1)] = b2;
      mdl.mem[16'(pc + 16'h2)] = b3;
      e = '{pc, op, 2'h1, 3'h7, 2'h3, {b3, b2}, pair_of(op[5:4]), IOA_BR_NONE};
      case (k)
         0: e = '{pc, op, 2'h3, IOA_MODE_DIRECT, 2'h0, {b3, b2}, e.pv, IOA_BR_NONE};
         1: e = '{pc, op, 2'h2, IOA_MODE_IMM, 2'h1, {8'h00, b2}, e.pv, IOA_BR_NONE};
         2: e = '{pc, op, 2'h3, IOA_MODE_IMM, 2'h1, {b3, b2}, e.pv, IOA_BR_NONE};
         3: e = '{pc, op, 2'h1, IOA_MODE_REG, 2'h2, {8'h00, rg[op[2:0]]}, e.pv, IOA_BR_NONE};
         4: e = '{pc, op, 2'h1, IOA_MODE_INDIRECT, 2'h0, op[6] ? pair_of(2'h2) : pair_of(op[5:4]), e.pv, IOA_BR_NONE};
         5: begin
            e.len = 2'h3;
            e.mode = IOA_MODE_NONE;
            e.bk = IOA_BR_DIRECT;
         end
         6: begin
            e.v0 = pair_of(2'h2);
            e.mode = IOA_MODE_INDIRECT;
            e.bk = IOA_BR_INDIRECT;
         end
         default: begin
            e.v0 = {10'h000, op[5:3], 3'h0};
            e.mode = IOA_MODE_NONE;
            e.bk = IOA_BR_VECTOR;
         end
      endcase
      q.push_back(e);
      n = 0;
      while (iv !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n == 300) begin
         num_errors++;
      end
      done <= 1'b1;
      take <= (k > 4);
      @(posedge clk);
      done <= 1'b0;
      take <= 1'b0;
      pc = (k > 4) ? e.v0 : 16'(pc + e.len);
   endtask
   always @(posedge clk) begin
      ioa_exp_s m;
      if (iv === 1'b1 && ivp !== 1'b1) begin
         if (q.size() == 0) begin
            num_errors++;
         end else begin
            m = q.pop_front();
            chk(ia, m.addr);
            chk({iop, 6'h00, ilen}, {m.op, 6'h00, m.len});
            if (m.mode != 3'h7) begin
               chk({13'h0000, imode}, {13'h0000, m.mode});
            end
            chk(pairo, m.pv);
            chk({14'h0000, bk}, {14'h0000, m.bk});
            case (m.sel)
               2'h0: chk(oaddr, m.v0);
               2'h1: chk(imm, m.v0);
               2'h2: chk({8'h00, src}, m.v0);
               default: chk(bt, m.v0);
            endcase
         end
      end
      ivp <= iv;
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      chk({14'h0000, mem_rd, iv}, 16'h0000);
      rst_n <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         exec(8'h3a, 0);
         exec(8'h06, 1);
         for (int p = 0; p < 4; p++) begin
            exec({2'h0, 2'(p), 4'h1}, 2);
         end
         for (int s = 0; s < 8; s++) begin
            if (s != 6) begin
               exec({5'h08, 3'(s)}, 3);
            end
         end
         exec(8'h0a, 4);
         exec(8'h1a, 4);
         exec(8'h7e, 4);
         exec(8'hc3, 5);
         exec(8'he9, 6);
         for (int v = 0; v < 8; v++) begin
            exec({2'h3, 3'(v), 3'h7}, 7);
         end
      end
      repeat (2) @(posedge clk);
      chk(16'(q.size()), 16'h0000);
      conclude();
   end
endmodule
